// >>> hdl/lnd_decoder.sv
// Local firmware ROM and parameter RAM decoder with AXI4-Lite control
// Overview of operation
// R1: Firmware store: four banks, two byte parts
// R2: Banks held off while address strobe active
// R3: Banks enabled only on read status
// R4: Default wait strap adds one wait state
// R5: Altered wait strap gives ready immediately
// R6: Default space decodes F8000 to FFFFF
// R7: Reduced space decodes only FC000 up
// R8: Third space setting never hits firmware
// R9: Firmware hit follows latched address range
// R10: Bank chosen by bits 14:13, top ones
// R11: Address bits 1 to 11 form word
// R12: Selected bank drives full sixteen bits
// R13: RAM 512 bytes at I/O FE00-FFFF
// R14: RAM hit on I/O range access
// R15: Low byte: hit, read, bit0 low
// R16: High byte: same, with high enable
// R17: RAM writes on transmit, drives on receive
// R18: RAM command is write OR read
// R19: Processor must raise early write to write
// R20: Writes use early write, same byte select
// R21: Power-on init disables all RAM parts
// R22: No hit means no data driven
// R23: Straps are static configuration settings
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module lnd_decoder
   import lnd_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Latched processor bus
   input wire logic [19:0] latched_addr_in,
   input wire logic ale_in,
   input wire logic latched_read_status_in,
   input wire logic latched_status_bit2_in,
   input wire logic latched_high_byte_enable_in,
   input wire logic read_strobe_in,
   input wire logic early_write_strobe_in,
   input wire logic data_direction_in,
   input wire logic power_init_in,
   input wire logic [15:0] data_in,
   // Memory enables and local data bus
   output logic [3:0] fw_bank_en_out,
   output logic [10:0] fw_word_addr_out,
   output logic ram_lo_en_out,
   output logic ram_hi_en_out,
   output logic ram_cmd_out,
   output logic local_fw_hit_out,
   output logic local_ram_hit_out,
   output logic fw_ready_out,
   output logic [15:0] data_out,
   output logic [1:0] data_oe_out,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // Storage and decode nets
   // ----------------------------------------------------------------
   lnd_state_t s_r; // Registered state
   lnd_state_t s_nxt; // Next state
   // Banks side by side, low then high byte in each word
   logic [15:0] fw_mem [0:LND_FW_WORDS-1];
   logic [7:0] ram_lo_mem [0:LND_RAM_LANE_BYTES-1]; // Even bytes
   logic [7:0] ram_hi_mem [0:LND_RAM_LANE_BYTES-1]; // Odd bytes
   logic fw_hit; // Address in enabled firmware space
   logic fw_read; // Firmware read, address stable
   logic [3:0] bank_dec; // One-hot bank select
   logic ram_hit; // I/O address in RAM range
   logic ram_ok; // RAM hit outside power-on init
   logic rd_lo, rd_hi; // RAM byte read selects
   logic wr_lo, wr_hi; // RAM byte write selects
   logic reg_wr; // Register write fires this cycle
   logic load_we; // Firmware load port write

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Offset is one of the mapped registers
   function automatic logic lnd_known(input logic [7:0] a);
      lnd_known = (a == LND_OFF_CTRL) || (a == LND_OFF_STATUS) ||
         (a == LND_OFF_LOAD_ADDR) || (a == LND_OFF_LOAD_DATA) ||
         (a == LND_OFF_FW_COUNT);
   endfunction

   // One RAM byte lane: selected, strobed and qualified
   function automatic logic lnd_lane(input logic ok, input logic strobe,
                                     input logic sel);
      lnd_lane = ok & strobe & sel;
   endfunction

   // ----------------------------------------------------------------
   // Address decoding
   // ----------------------------------------------------------------
   // Firmware space by strap, memory cycles only
   always_comb begin
      fw_hit = 1'b0;
      if (latched_status_bit2_in) begin
         case (s_r.fw_space)
            // R6: full space, all five top bits set
            LND_SPACE_FULL: fw_hit = latched_addr_in[19:15] == LND_FW_TOP5;
            // R7: reduced space, upper half only
            LND_SPACE_HALF: fw_hit = latched_addr_in[19:14] == LND_FW_TOP6;
            // R8: no local firmware at all
            default: fw_hit = 1'b0;
         endcase
      end
   end

   // R2: no bank while strobe high; R3: read status only
   assign fw_read = fw_hit & ~ale_in & ~latched_read_status_in;

   // R10: one bank per value of bits 14:13, bit 12 ignored
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_bank
         assign bank_dec[b] = fw_read & (latched_addr_in[14:13] == 2'(b));
      end
   endgenerate

   // R13: upper 512 bytes of 16-bit I/O space; R14: I/O cycles
   assign ram_hit = ~latched_status_bit2_in &
      (latched_addr_in[15:9] == LND_RAM_TOP7);
   // R21: init overrides every other access condition
   assign ram_ok = ram_hit & ~power_init_in;
   // R15: low lane on even address
   assign rd_lo = lnd_lane(ram_ok, read_strobe_in, ~latched_addr_in[0]);
   // R16: high lane on high byte enable
   assign rd_hi = lnd_lane(ram_ok, read_strobe_in,
                           latched_high_byte_enable_in);
   // R20: writes use early write and the same lane selects
   assign wr_lo = lnd_lane(ram_ok, early_write_strobe_in,
                           ~latched_addr_in[0]);
   assign wr_hi = lnd_lane(ram_ok, early_write_strobe_in,
                           latched_high_byte_enable_in);

   // ----------------------------------------------------------------
   // Memory arrays
   // ----------------------------------------------------------------
   assign reg_wr = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
   assign load_we = reg_wr & (s_r.awaddr == LND_OFF_LOAD_DATA) &
      (s_r.wstrb[1:0] == 2'h3);

   // Firmware loads via software; RAM captures bus data
   always_ff @(posedge clock_in) begin
      if (load_we) begin
         fw_mem[s_r.load_addr] <= s_r.wdata[15:0];
      end
      // R17: capture only while direction is transmit
      // R19: nothing is written without the early write strobe
      if (wr_lo && !data_direction_in) begin
         ram_lo_mem[latched_addr_in[8:1]] <= data_in[7:0];
      end
      if (wr_hi && !data_direction_in) begin
         ram_hi_mem[latched_addr_in[8:1]] <= data_in[15:8];
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Bus slave, straps, ready sequencer and memory outputs
   always_comb begin
      s_nxt = s_r;
      // Drop answers the master has taken
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // Write address and data may come in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      // Both halves held: perform the write and answer
      if (reg_wr) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = lnd_known(s_r.awaddr) ? LND_RESP_OKAY :
            LND_RESP_SLVERR;
         // R23: straps are set by software between bus cycles
         if (s_r.awaddr == LND_OFF_CTRL && s_r.wstrb[0]) begin
            s_nxt.fw_no_wait = s_r.wdata[LND_CTRL_NO_WAIT_BIT];
            s_nxt.fw_space =
               s_r.wdata[LND_CTRL_SPACE_LSB +: 2];
         end
         if (s_r.awaddr == LND_OFF_LOAD_ADDR && s_r.wstrb[1:0] == 2'h3) begin
            s_nxt.load_addr = s_r.wdata[12:0];
         end
         // Load port steps on so an image streams in
         if (load_we) begin
            s_nxt.load_addr = s_r.load_addr + 13'h0001;
         end
      end
      // Read request answered the next cycle
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = lnd_known(s_axi_araddr) ? LND_RESP_OKAY :
            LND_RESP_SLVERR;
         case (s_axi_araddr)
            LND_OFF_CTRL: s_nxt.rdata = {29'h0, s_r.fw_space,
                                         s_r.fw_no_wait};
            LND_OFF_STATUS: s_nxt.rdata = {27'h0, power_init_in,
                                           s_r.ready, s_r.ram_hit,
                                           s_r.fw_hit, 1'b0};
            LND_OFF_LOAD_ADDR: s_nxt.rdata = {19'h0, s_r.load_addr};
            LND_OFF_FW_COUNT: s_nxt.rdata = {16'h0, s_r.fw_count};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      // One request of each kind in flight, no new one while answering
      s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
      s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;
      s_nxt.arready = ~s_nxt.rvalid;

      // Ready sequencer for local firmware reads
      case (s_r.fa_state)
         LND_FA_IDLE: begin
            if (fw_read) begin
               s_nxt.fw_count = s_r.fw_count + 16'h0001;
               // R5: altered strap, ready on the hit itself
               // R4: default strap, one extra wait state
               s_nxt.fa_state = s_r.fw_no_wait ? LND_FA_READY :
                  LND_FA_WAIT;
            end
         end
         LND_FA_WAIT: begin
            s_nxt.fa_state = fw_read ? LND_FA_READY : LND_FA_IDLE;
         end
         LND_FA_READY: begin
            s_nxt.fa_state = fw_read ? LND_FA_READY : LND_FA_IDLE;
         end
         default: s_nxt.fa_state = LND_FA_IDLE;
      endcase
      s_nxt.ready = s_nxt.fa_state == LND_FA_READY;

      // R9: hit reported for the enabled range
      s_nxt.fw_hit = fw_hit;
      s_nxt.ram_hit = ram_hit;
      // R1: bank enable covers both byte parts of a bank
      s_nxt.bank_en = bank_dec;
      // R11: word address from bits 1 to 11
      s_nxt.word_addr = latched_addr_in[11:1];
      // R21: init masks every RAM enable
      s_nxt.ram_lo_en = rd_lo | wr_lo;
      s_nxt.ram_hi_en = rd_hi | wr_hi;
      // R18: command strobe as OR of the two strobes
      s_nxt.ram_cmd = early_write_strobe_in | read_strobe_in;
      // R22: nothing driven by default
      s_nxt.data_oe = 2'h0;
      s_nxt.data = 16'h0;
      if (fw_read) begin
         // R12: both parts drive the whole word
         s_nxt.data = fw_mem[{latched_addr_in[14:13],
                              latched_addr_in[11:1]}];
         s_nxt.data_oe = 2'h3;
      end else if (data_direction_in) begin
         // R17: RAM drives only while direction is receive
         s_nxt.data = {ram_hi_mem[latched_addr_in[8:1]],
                       ram_lo_mem[latched_addr_in[8:1]]};
         s_nxt.data_oe = {rd_hi, rd_lo};
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Synchronous reset; straps come up in default positions
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         s_r <= '0;
         s_r.fw_no_wait <= LND_NO_WAIT_RESET;
         s_r.fw_space <= LND_SPACE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign fw_bank_en_out = s_r.bank_en;
   assign fw_word_addr_out = s_r.word_addr;
   assign ram_lo_en_out = s_r.ram_lo_en;
   assign ram_hi_en_out = s_r.ram_hi_en;
   assign ram_cmd_out = s_r.ram_cmd;
   assign local_fw_hit_out = s_r.fw_hit;
   assign local_ram_hit_out = s_r.ram_hit;
   assign fw_ready_out = s_r.ready;
   assign data_out = s_r.data;
   assign data_oe_out = s_r.data_oe;
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_start_wait;
      s_r.fa_state == LND_FA_IDLE && fw_read && !s_r.fw_no_wait;
   endsequence
   sequence s_start_fast;
      s_r.fa_state == LND_FA_IDLE && fw_read && s_r.fw_no_wait;
   endsequence

   property p_ale_off;
      ale_in |=> fw_bank_en_out == 4'h0;
   endproperty
   a_ale_off: assert property (p_ale_off) // R2
      else $error("bank enabled during address strobe");

   property p_write_off;
      latched_read_status_in |=> fw_bank_en_out == 4'h0;
   endproperty
   a_write_off: assert property (p_write_off) // R3
      else $error("bank enabled on write cycle");

   property p_one_wait;
      s_start_wait ##1 fw_read |-> !fw_ready_out ##1 fw_ready_out;
   endproperty
   a_one_wait: assert property (p_one_wait) // R4
      else $error("default strap did not give one wait state");

   property p_no_wait;
      s_start_fast |=> fw_ready_out;
   endproperty
   a_no_wait: assert property (p_no_wait) // R5
      else $error("altered strap did not give immediate ready");

   property p_full_space;
      s_r.fw_space == LND_SPACE_FULL && latched_status_bit2_in &&
         latched_addr_in[19:15] == LND_FW_TOP5 |=> local_fw_hit_out;
   endproperty
   a_full_space: assert property (p_full_space) // R6
      else $error("full space missed firmware hit");

   property p_half_space;
      s_r.fw_space == LND_SPACE_HALF && latched_addr_in[19:14] == 6'h3E
         |=> !local_fw_hit_out;
   endproperty
   a_half_space: assert property (p_half_space) // R7
      else $error("reduced space hit lower half");

   property p_none_space;
      s_r.fw_space == LND_SPACE_NONE |=> !local_fw_hit_out;
   endproperty
   a_none_space: assert property (p_none_space) // R8
      else $error("firmware hit with space disabled");

   property p_bank_pick;
      fw_read |=> fw_bank_en_out == (4'h1 << $past(latched_addr_in[14:13]));
   endproperty
   a_bank_pick: assert property (p_bank_pick) // R10
      else $error("wrong bank selected");

   property p_init_off;
      power_init_in |=> !ram_lo_en_out && !ram_hi_en_out;
   endproperty
   a_init_off: assert property (p_init_off) // R21
      else $error("RAM enabled during init");

   property p_cmd_or;
      ##1 ram_cmd_out == $past(early_write_strobe_in | read_strobe_in);
   endproperty
   a_cmd_or: assert property (p_cmd_or) // R18
      else $error("RAM command is not the OR of strobes");

   property p_idle_float;
      !fw_hit && !ram_hit |=> data_oe_out == 2'h0;
   endproperty
   a_idle_float: assert property (p_idle_float) // R22
      else $error("data driven without a hit");
endmodule
`default_nettype wire

// >>> hdl/lnd_pkg.sv
// Package of constants and types for the local ROM and NVRAM decoder
`default_nettype none
package lnd_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] LND_OFF_CTRL = 8'h00;
   localparam logic [7:0] LND_OFF_STATUS = 8'h04;
   localparam logic [7:0] LND_OFF_LOAD_ADDR = 8'h08;
   localparam logic [7:0] LND_OFF_LOAD_DATA = 8'h0C;
   localparam logic [7:0] LND_OFF_FW_COUNT = 8'h10;
   // Control field positions and reset values
   localparam int LND_CTRL_NO_WAIT_BIT = 0;
   localparam int LND_CTRL_SPACE_LSB = 1;
   localparam logic LND_NO_WAIT_RESET = 1'b0;
   localparam logic [1:0] LND_SPACE_RESET = 2'h0;
   // Firmware address space strap settings
   localparam logic [1:0] LND_SPACE_FULL = 2'h0;
   localparam logic [1:0] LND_SPACE_HALF = 2'h1;
   localparam logic [1:0] LND_SPACE_NONE = 2'h2;
   // ----------------------------------------------------------------
   // Address decode constants
   // ----------------------------------------------------------------
   localparam logic [4:0] LND_FW_TOP5 = 5'h1F;
   localparam logic [5:0] LND_FW_TOP6 = 6'h3F;
   localparam logic [6:0] LND_RAM_TOP7 = 7'h7F;
   localparam int LND_FW_WORDS = 8192;
   localparam int LND_RAM_LANE_BYTES = 256;
   // AXI responses
   localparam logic [1:0] LND_RESP_OKAY = 2'h0;
   localparam logic [1:0] LND_RESP_SLVERR = 2'h2;
   // Firmware ready sequencer, Gray along idle, wait, ready
   typedef enum logic [1:0] {
      LND_FA_IDLE = 2'h0,
      LND_FA_WAIT = 2'h1,
      LND_FA_READY = 2'h3
   } lnd_fa_state_t;
   // All flip-flop state of the decoder
   typedef struct packed {
      logic fw_no_wait;
      logic [1:0] fw_space;
      logic [12:0] load_addr;
      logic [15:0] fw_count;
      lnd_fa_state_t fa_state;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [3:0] bank_en;
      logic [10:0] word_addr;
      logic ram_lo_en;
      logic ram_hi_en;
      logic ram_cmd;
      logic fw_hit;
      logic ram_hit;
      logic ready;
      logic [15:0] data;
      logic [1:0] data_oe;
   } lnd_state_t;
endpackage
`default_nettype wire

// >>> hdl/README_unused.sv
// Intentionally empty compile unit
`default_nettype none
`default_nettype wire

// >>> verif/lnd_cpu_model.sv
// Processor bus model presenting latched cycles to the decoder
`default_nettype none
module lnd_cpu_model
   import lnd_pkg::*;
(
   // Clock
   input wire logic clock_in,
   // Latched bus toward the decoder
   output logic [19:0] addr_out,
   output logic ale_out,
   output logic rd_stat_out,
   output logic mem_out,
   output logic hbe_out,
   output logic rd_out,
   output logic wr_out,
   output logic dir_out,
   output logic init_out,
   output logic [15:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet bus at time zero
   initial begin
      addr_out = 20'h00000;
      ale_out = 1'b1;
      rd_stat_out = 1'b0;
      mem_out = 1'b0;
      hbe_out = 1'b0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      dir_out = 1'b1;
      init_out = 1'b0;
      data_out = 16'h5A5A;
   end
   // Kinds: 0 idle, 1 mem rd, 2 mem wr, 3 io rd, 4 io wr, 5 rd with ale
   // Call only at a rising edge
   task automatic cyc(input int k, input logic [19:0] a, input logic h,
                      input logic [15:0] d);
      addr_out <= a;
      ale_out <= (k == 0 || k == 5);
      mem_out <= (k < 3 || k == 5);
      rd_stat_out <= (k == 2 || k == 4);
      hbe_out <= h;
      rd_out <= (k == 1 || k == 3 || k == 5);
      wr_out <= (k == 2 || k == 4);
      dir_out <= !(k == 2 || k == 4);
      // Released bus shows inverse, never stale data
      data_out <= (k == 2 || k == 4) ? d : ~data_out;
   endtask
   // Power-on init level
   task automatic set_init(input logic v);
      init_out <= v;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the local firmware and RAM decoder
`default_nettype none
module tb;
   import lnd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, rst_b_in;
   logic [19:0] la;
   logic ale, rs, mb, hbe, rd, wr, dir, init;
   logic [15:0] din, dout;
   logic [3:0] bank, wstrb;
   logic [10:0] wa;
   logic rlo, rhi, rcmd, fhit, rhit, rdy;
   logic [1:0] oe, bresp, rresp, r;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d, c0;
   logic [19:0] fa [5];
   logic [15:0] fw [5];
   logic [15:0] w, ra;
   logic [7:0] b;
   logic [12:0] idx;
   logic h;
   int errors, n_tests, hits;
   // Clock, 4 ns period
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   lnd_decoder DUT (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .latched_addr_in(la), .ale_in(ale), .latched_read_status_in(rs),
      .latched_status_bit2_in(mb), .latched_high_byte_enable_in(hbe),
      .read_strobe_in(rd), .early_write_strobe_in(wr),
      .data_direction_in(dir), .power_init_in(init), .data_in(din),
      .fw_bank_en_out(bank), .fw_word_addr_out(wa), .ram_lo_en_out(rlo),
      .ram_hi_en_out(rhi), .ram_cmd_out(rcmd), .local_fw_hit_out(fhit),
      .local_ram_hit_out(rhit), .fw_ready_out(rdy), .data_out(dout),
      .data_oe_out(oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   lnd_cpu_model cpu (.clock_in(clock_in), .addr_out(la), .ale_out(ale),
      .rd_stat_out(rs), .mem_out(mb), .hbe_out(hbe), .rd_out(rd),
      .wr_out(wr), .dir_out(dir), .init_out(init), .data_out(din));
   // Compare and count
   task automatic check(input string nm, input logic [31:0] s,
                        input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Verdict and end of run
   task automatic results();
      $display("Checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // AXI4-Lite write, both halves offered together
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                            output logic [1:0] res);
      logic ga, gw;
      @(posedge clock_in);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ga = 1'b0;
      gw = 1'b0;
      while (!(ga && gw)) begin
         @(posedge clock_in);
         if (!ga && awready === 1'b1) begin
            ga = 1'b1;
            awvalid <= 1'b0;
         end
         if (!gw && wready === 1'b1) begin
            gw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clock_in);
      res = bresp;
      bready <= 1'b0;
   endtask
   // AXI4-Lite read
   task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                           output logic [1:0] res);
      @(posedge clock_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock_in);
      v = rdata;
      res = rresp;
      rready <= 1'b0;
   endtask
   // One bus cycle, sampled after the registering edge
   task automatic put(input int k, input logic [19:0] a, input logic hb,
                      input logic [15:0] v);
      @(posedge clock_in);
      cpu.cyc(k, a, hb, v);
      @(posedge clock_in);
      #1;
   endtask
   // Watchdog, generous against about 300 cycles of tests
   initial begin
      #100000;
      errors++;
      results();
   end
   // Main sequence
   initial begin
      void'($urandom(82877));
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      rst_b_in = 1'b0;
      errors = 0;
      n_tests = 0;
      hits = 0;
      repeat (10) @(posedge clock_in);
      rst_b_in <= 1'b1;
      axi_read(LND_OFF_CTRL, d, r);
      check("ctrl reset", {r, d[2:0]}, 5'h00);
      axi_read(8'h14, d, r);
      check("unmapped rresp", r, LND_RESP_SLVERR);
      check("unmapped rdata", d, 32'h0);
      axi_write(8'h14, 32'hFFFFFFFF, r);
      check("unmapped wr", r, LND_RESP_SLVERR);
      // Load one random word per bank, then one miss address
      for (int i = 0; i < 4; i++) begin
         idx = {2'(i), 11'($urandom)};
         fa[i] = {5'h1F, idx[12:11], 1'($urandom), idx[10:0], 1'b0};
         fw[i] = 16'($urandom);
         axi_write(LND_OFF_LOAD_ADDR, {19'h0, idx}, r);
         axi_write(LND_OFF_LOAD_DATA, {16'h0, fw[i]}, r);
      end
      fa[4] = 20'hF7FFE;
      fw[4] = 16'h0000;
      axi_read(LND_OFF_FW_COUNT, c0, r);
      // Every space strap with both wait straps
      for (int s = 0; s < 3; s++) begin
         for (int n = 0; n < 2; n++) begin
            axi_write(LND_OFF_CTRL, {29'h0, 2'(s), 1'(n)}, r);
            for (int j = 0; j < 5; j++) begin
               h = (s == 0) ? (fa[j][19:15] == 5'h1F) :
                   (s == 1) ? (fa[j][19:14] == 6'h3F) : 1'b0;
               put(1, fa[j], 1'b1, 16'h0);
               check("fw hit", fhit, h);
               check("bank", bank, h ? 4'h1 << fa[j][14:13] : 4'h0);
               check("word", wa, fa[j][11:1]);
               check("fw oe", oe, h ? 2'h3 : 2'h0);
               check("fw data", h ? dout : 16'h0, h ? fw[j] : 16'h0);
               check("ready c1", rdy, h & 1'(n));
               put(1, fa[j], 1'b1, 16'h0);
               check("ready c2", rdy, h);
               put(0, 20'h0, 1'b0, 16'h0);
               hits += int'(h);
            end
         end
      end
      axi_read(LND_OFF_FW_COUNT, d, r);
      check("fw count", 16'(d[15:0] - c0[15:0]), 16'(hits));
      axi_write(LND_OFF_CTRL, 32'h0, r);
      put(2, fa[0], 1'b1, 16'h1234);
      check("write bank", {bank, oe}, 6'h00);
      put(5, fa[0], 1'b1, 16'h0);
      check("ale bank", bank, 4'h0);
      // Parameter RAM lanes
      ra = {7'h7F, 8'($urandom), 1'b0};
      w = 16'($urandom);
      b = 8'($urandom);
      put(4, {4'h0, ra}, 1'b1, w);
      check("ram wr", {rhit, rlo, rhi, rcmd}, 4'hF);
      put(4, {4'h0, ra | 16'h1}, 1'b1, {b, 8'h00});
      check("ram hi wr", {rlo, rhi}, 2'h1);
      put(3, {4'h0, ra}, 1'b1, 16'h0);
      check("ram rd", {rcmd, oe, dout}, {3'h7, b, w[7:0]});
      put(3, {4'h0, ra}, 1'b0, 16'h0);
      check("ram lo", {rhi, oe, dout[7:0]}, {3'h1, w[7:0]});
      put(0, 20'h0, 1'b0, 16'h0);
      check("idle", {rcmd, oe}, 3'h0);
      put(3, 20'h0FD00, 1'b1, 16'h0);
      check("ram miss", {rhit, oe}, 3'h0);
      @(posedge clock_in);
      cpu.set_init(1'b1);
      put(4, {4'h0, ra}, 1'b1, ~w);
      check("init off", {rlo, rhi}, 2'h0);
      axi_read(LND_OFF_STATUS, d, r);
      check("status init", d[4], 1'b1);
      // Idle the bus first, or the held write lands once init drops
      put(0, 20'h0, 1'b0, 16'h0);
      @(posedge clock_in);
      cpu.set_init(1'b0);
      put(3, {4'h0, ra}, 1'b1, 16'h0);
      check("ram kept", dout, {b, w[7:0]});
      results();
   end
endmodule
`default_nettype wire
